// [src/itc_ctrl.sv]
/*
 * Integration timing controller: timing register, mode sequencer, preset timer and
 * sync pulse counter for the four converter channels.
 * Assumes conv_enable and the register port come from logic on clk; sync_pin is a pin.
 */
`timescale 1ns/1ps
`include "itc_cfg.svh"

// Summary of operation
// - accumulate mode stops on selected sync edge
// - mode 00 restarts conversions automatically
// - preset times 12, 100, 400 ms
// - mode 01 follows conversion enable bit
// - mode 10 one cycle 2.4 us after sync
// - mode 11 integrates over sync pulses
// - pulse count is two to the parameter, at most 256
// - integration only while enable is set
// - done flag set on every completed cycle
module itc_ctrl
    import itc_pkg::*;
#(
    parameter int T_SHORT_CYC = `ITC_US_TO_CYC(`ITC_T_SHORT_US),
    parameter int T_MID_CYC   = `ITC_US_TO_CYC(`ITC_T_MID_US),
    parameter int T_LONG_CYC  = `ITC_US_TO_CYC(`ITC_T_LONG_US)
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // control
    input  wire logic       conv_enable,
    input  wire logic       sync_pin,
    // status
    output logic            integrating,
    output logic            cycle_done,
    output logic            conv_done
);
    localparam int SYNC_DLY = `ITC_NS_TO_CYC_UP(`ITC_SYNC_DLY_NS);

    typedef struct packed {
        itc_state_t  fsm;
        itc_mode_t   mode;
        logic [3:0]  timing_parameter;
        logic        stop_edge;
        logic [23:0] timer;
        logic [8:0]  pulse_cnt;
        logic [7:0]  timing;
        logic [7:0]  rdata;
        logic        en_q;
        logic [7:0]  en_run;
        logic        integ;
        logic        done_pulse;
        logic        done_flag;
    } itc_st_t;

    itc_st_t st_reg;
    itc_st_t st_next;
    logic    sync_rise;
    logic    sync_fall;
    logic    stop_hit;

    // ============================================================
    // decoders
    function automatic logic [23:0] preset_load(input logic [3:0] code);
        case (code)
            4'h1:    preset_load = 24'(T_MID_CYC - 1);
            4'h2:    preset_load = 24'(T_LONG_CYC - 1);
            // unlisted codes fall back to the shortest time
            default: preset_load = 24'(T_SHORT_CYC - 1);
        endcase
    endfunction : preset_load

    function automatic logic [8:0] pulse_last(input logic [3:0] code);
        logic [3:0] c;
        c = (code > `ITC_MAX_PULSE_CODE) ? `ITC_MAX_PULSE_CODE : code;
        pulse_last = 9'((9'h001 << c) - 9'h001);
    endfunction : pulse_last

    // ============================================================
    // sync pin
    itc_sync_edge u_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .sync_pin  (sync_pin),
        .sync_rise (sync_rise),
        .sync_fall (sync_fall)
    );

    assign stop_hit = st_reg.stop_edge ? sync_rise : sync_fall;

    // ============================================================
    // sequencer
    always_comb begin
        st_next            = st_reg;
        st_next.done_pulse = 1'b0;
        st_next.en_q       = conv_enable;
        // length of the current enable run, saturating; only the checks read it
        if (!conv_enable) begin
            st_next.en_run = 8'h00;
        end else if (st_reg.en_run != 8'hff) begin
            st_next.en_run = st_reg.en_run + 8'h01;
        end

        if (reg_wr && reg_addr == `ITC_TIMING_OFS) begin
            st_next.timing = {1'b0, reg_wdata[`ITC_EDGE_BIT:0]};
        end
        if (reg_rd) begin
            if (reg_addr == `ITC_TIMING_OFS) begin
                st_next.rdata = st_reg.timing;
            end else begin
                st_next.rdata = 8'h00;
            end
        end
        if (conv_enable && !st_reg.en_q) begin
            st_next.done_flag = 1'b0;
        end

        case (st_reg.fsm)
            ITC_IDLE: begin
                if (conv_enable) begin
                    // settings only take hold here, so mid-cycle writes wait
                    st_next.mode      = itc_mode_t'(st_reg.timing[`ITC_MODE_HI:`ITC_MODE_LO]);
                    st_next.timing_parameter     = st_reg.timing[`ITC_TIMING_PARAMETER_HI:`ITC_TIMING_PARAMETER_LO];
                    st_next.stop_edge = st_reg.timing[`ITC_EDGE_BIT];
                    st_next.timer     = preset_load(st_next.timing_parameter);
                    st_next.pulse_cnt = 9'h000;
                    if (st_next.mode == ITC_MODE_ONESHOT) begin
                        st_next.fsm = ITC_ARM;
                    end else begin
                        st_next.fsm = ITC_INTEG;
                    end
                end
            end
            ITC_ARM: begin
                if (sync_rise) begin
                    st_next.timer = 24'(SYNC_DLY - 1);
                    st_next.fsm   = ITC_DELAY;
                end
            end
            ITC_DELAY: begin
                if (st_reg.timer == 24'h00_0000) begin
                    st_next.timer = preset_load(st_reg.timing_parameter);
                    st_next.fsm   = ITC_INTEG;
                end else begin
                    st_next.timer = st_reg.timer - 24'h00_0001;
                end
            end
            ITC_INTEG: begin
                case (st_reg.mode)
                    ITC_MODE_FREE, ITC_MODE_ONESHOT: begin
                        if (st_reg.timer == 24'h00_0000) begin
                            st_next.done_pulse = 1'b1;
                            // free run goes through idle to pick up new settings
                            st_next.fsm = (st_reg.mode == ITC_MODE_FREE) ? ITC_IDLE
                                                                          : ITC_HALT;
                        end else begin
                            st_next.timer = st_reg.timer - 24'h00_0001;
                        end
                    end
                    ITC_MODE_ACCUM: begin
                        if (stop_hit) begin
                            if (st_reg.pulse_cnt == pulse_last(st_reg.timing_parameter)) begin
                                st_next.done_pulse = 1'b1;
                                st_next.fsm        = ITC_IDLE;
                            end else begin
                                st_next.pulse_cnt = st_reg.pulse_cnt + 9'h001;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
            ITC_HALT: begin
            end
            default: st_next.fsm = ITC_IDLE;
        endcase

        if (!conv_enable) begin
            st_next.fsm = ITC_IDLE;
            if (st_reg.fsm == ITC_INTEG && st_reg.mode == ITC_MODE_MANUAL) begin
                st_next.done_pulse = 1'b1;
            end
        end
        if (st_next.done_pulse) begin
            st_next.done_flag = 1'b1;
        end
        st_next.integ = (st_next.fsm == ITC_INTEG);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg        <= '0;
            st_reg.fsm    <= ITC_IDLE;
            st_reg.mode   <= ITC_MODE_FREE;
            st_reg.timing <= `ITC_TIMING_RST;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata   = st_reg.rdata;
    assign integrating = st_reg.integ;
    assign cycle_done  = st_reg.done_pulse;
    assign conv_done   = st_reg.done_flag;

    // ============================================================
    // checks
    a_stop_edge: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        (cycle_done && st_reg.mode == ITC_MODE_ACCUM) |->
            $past(st_reg.stop_edge ? sync_rise : sync_fall))
        else $error("accumulate cycle ended without the selected sync edge");

    a_free_restart: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        (cycle_done && st_reg.mode == ITC_MODE_FREE && conv_enable && $past(conv_enable))
            ##1 conv_enable |-> ##1 integrating)
        else $error("free run did not restart");

    a_preset_len: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        ($rose(integrating) && st_reg.mode != ITC_MODE_ACCUM
            && st_reg.mode != ITC_MODE_MANUAL) |-> st_reg.timer == preset_load(st_reg.timing_parameter))
        else $error("preset timer loaded wrong");

    a_manual_stop: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        (integrating && st_reg.mode == ITC_MODE_MANUAL && !conv_enable)
            |=> !integrating && cycle_done)
        else $error("manual stop missed");

    a_sync_delay: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        (st_reg.fsm == ITC_ARM && sync_rise && conv_enable)
            |-> ##48 !integrating ##1 (integrating || st_reg.en_run < 8'h31))
        else $error("one-shot start delay wrong");

    a_one_shot: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        (cycle_done && st_reg.mode == ITC_MODE_ONESHOT && conv_enable)
            |-> st_reg.fsm == ITC_HALT && !integrating)
        else $error("one-shot ran more than one cycle");

    a_pulse_count: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        (cycle_done && st_reg.mode == ITC_MODE_ACCUM)
            |-> $past(st_reg.pulse_cnt) == pulse_last(st_reg.timing_parameter))
        else $error("pulse count wrong");

    a_enable_gate: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        integrating |-> $past(conv_enable))
        else $error("integrating without enable");

    a_done_flag: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        cycle_done |-> conv_done)
        else $error("done flag not set");

    a_resv_zero: assert property (@(posedge clk) disable iff (sys_rst || !ce)
        !st_reg.timing[`ITC_RESV_BIT] and (integrating && $past(integrating)
            |-> $stable(st_reg.timing_parameter) && $stable(st_reg.mode)))
        else $error("reserved bit set or settings changed mid-cycle");

endmodule : itc_ctrl

// [src/itc_cfg.svh]
/*
 * Constants for the integration timing controller: register offset, field positions,
 * reset value and timing figures.
 * Assumes a 20 MHz system clock; included by bare name.
 */
`ifndef ITC_CFG_SVH
`define ITC_CFG_SVH

// ============================================================
// register map
`define ITC_TIMING_OFS      5'h01
`define ITC_TIMING_RST      8'h00
`define ITC_RESV_BIT        7
`define ITC_EDGE_BIT        6
`define ITC_MODE_HI         5
`define ITC_MODE_LO         4
`define ITC_TIMING_PARAMETER_HI        3
`define ITC_TIMING_PARAMETER_LO        0

// ============================================================
// timing
`define ITC_CLK_MHZ         20
`define ITC_T_SHORT_US      12000
`define ITC_T_MID_US        100000
`define ITC_T_LONG_US       400000
`define ITC_SYNC_DLY_NS     2400
`define ITC_US_TO_CYC(us)   ((us) * `ITC_CLK_MHZ)
`define ITC_NS_TO_CYC_UP(ns) (((ns) * `ITC_CLK_MHZ + 999) / 1000)
`define ITC_MAX_PULSE_CODE  4'h8

`endif

// [src/itc_pkg.sv]
/*
 * Types of the integration timing controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package itc_pkg;

    typedef enum logic [1:0] {
        ITC_MODE_FREE   = 2'h0,
        ITC_MODE_MANUAL = 2'h1,
        ITC_MODE_ONESHOT = 2'h2,
        ITC_MODE_ACCUM  = 2'h3
    } itc_mode_t;

    typedef enum logic [4:0] {
        ITC_IDLE  = 5'h01,
        ITC_ARM   = 5'h02,
        ITC_DELAY = 5'h04,
        ITC_INTEG = 5'h08,
        ITC_HALT  = 5'h10
    } itc_state_t;

endpackage : itc_pkg

// [src/itc_sync_edge.sv]
/*
 * Sync pin synchroniser and edge detector.
 * Assumes sync_pin is asynchronous to clk; edges come out one cycle wide.
 */
`timescale 1ns/1ps
module itc_sync_edge
    import itc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // pin
    input  wire logic sync_pin,
    // detected edges
    output logic      sync_rise,
    output logic      sync_fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
        logic fall;
    } itc_edge_st_t;

    itc_edge_st_t edge_reg;
    itc_edge_st_t edge_next;

    always_comb begin
        edge_next      = edge_reg;
        edge_next.s1   = sync_pin;
        edge_next.s2   = edge_reg.s1;
        // s1 feeds only s2
        edge_next.s3   = edge_reg.s2;
        edge_next.rise = edge_reg.s2 & ~edge_reg.s3;
        edge_next.fall = ~edge_reg.s2 & edge_reg.s3;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            edge_reg <= '0;
        end else if (ce) begin
            edge_reg <= edge_next;
        end
    end

    assign sync_rise = edge_reg.rise;
    assign sync_fall = edge_reg.fall;

endmodule : itc_sync_edge

// [bench/itc_sync_src.sv]
/*
 * Pulsed light source model: drives the sync pin with a train of pulses.
 * Assumes a 20 MHz clk; start is held one cycle and n_pulses is steady from start until busy falls.
 */
`timescale 1ns/1ps
module itc_sync_src #(
    parameter int HI_CYC = 1000,
    parameter int LO_CYC = 80
) (
    // clock
    input  wire logic       clk,
    // request
    input  wire logic       start,
    input  wire logic [8:0] n_pulses,
    // pin and status
    output logic            sync_pin,
    output logic            busy
);
    // ============================================================
    // pulse train; the pin is actively driven low between trains
    initial begin
        sync_pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (start) begin
                busy <= 1'b1;
                for (int i = 0; i < n_pulses; i++) begin
                    repeat (LO_CYC) @(posedge clk);
                    sync_pin <= 1'b1;
                    repeat (HI_CYC) @(posedge clk);
                    sync_pin <= 1'b0;
                end
                repeat (LO_CYC) @(posedge clk);
                busy <= 1'b0;
            end
        end
    end
endmodule : itc_sync_src

// [bench/tb_top.sv]
/*
 * Self-checking bench for the integration timing controller with a sync source model.
 * Assumes shortened preset times of 20/40/80 cycles and ce held high.
 */
`timescale 1ns/1ps
module tb_top;
    logic clk, sys_rst, reg_wr, reg_rd, conv_enable, start, sync_pin, busy;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic integrating, cycle_done, conv_done, rd_d, stop_rise, sp_prev;
    logic [8:0] n_p;
    logic [33:0] e;
    logic [33:0] exp_q[$];
    int n_errors = 0, num_checks = 0, len = 0, edges = 0, t, k;

    itc_ctrl #(.T_SHORT_CYC(20), .T_MID_CYC(40), .T_LONG_CYC(80)) itc_ctrl_i (
        .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_enable(conv_enable), .sync_pin(sync_pin), .integrating(integrating),
        .cycle_done(cycle_done), .conv_done(conv_done));
    itc_sync_src itc_sync_src_i (.clk(clk), .start(start), .n_pulses(n_p),
        .sync_pin(sync_pin), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ============================================================
    // helpers
    task automatic print_verdict();
        $display("checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic cmp(input logic [31:0] got, input logic [31:0] ex);
        num_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, ex);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back({26'h0, v});
        tick(1);
        reg_rd = 1'b0;
        tick(1);
    endtask : rd
    task automatic wait_done(input int n);
        t = 0;
        while (n > 0 && t < 20000) begin
            tick(1);
            t++;
            if (cycle_done === 1'b1) n--;
        end
        if (n > 0) begin
            n_errors++;
            print_verdict();
        end
    endtask : wait_done
    task automatic pulses(input logic [8:0] n);
        n_p = n;
        start = 1'b1;
        tick(1);
        start = 1'b0;
    endtask : pulses
    task automatic wait_idle();
        t = 0;
        while (busy !== 1'b0 && t < 12000) begin
            tick(1);
            t++;
        end
        if (t >= 12000) begin
            n_errors++;
            print_verdict();
        end
    endtask : wait_idle
    function automatic logic [31:0] tlen(input int p);
        return (p == 1) ? 32'h0000_0028 : (p == 2) ? 32'h0000_0050 : 32'h0000_0014;
    endfunction : tlen

    // ============================================================
    // result watcher: oldest note against each read or finished cycle
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : '1;
            cmp({24'h0, reg_rdata}, e[31:0]);
        end
        if (integrating === 1'b1 && sync_pin !== sp_prev && sync_pin === stop_rise) edges++;
        sp_prev = sync_pin;
        if (cycle_done === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : '1;
            cmp((e[33:32] == 2'd2) ? edges : len, e[31:0]);
        end
        if (integrating === 1'b1) len++;
        else begin
            len = 0;
            edges = 0;
        end
    end

    // ============================================================
    // main sequence
    initial begin
        {sys_rst, reg_wr, reg_rd, conv_enable, start, stop_rise} = 6'b10_0000;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        n_p = 9'h000;
        void'($urandom(63));
        tick(2);
        sys_rst = 1'b0;
        rd(5'h01, 8'h00);
        d = 8'($urandom);
        wr(5'h01, d);
        rd(5'h01, d & 8'h7f);
        wr(5'h02, 8'hff);
        rd(5'h02, 8'h00);
        rd(5'h01, d & 8'h7f);
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            wr(5'h01, 8'(p));
            exp_q.push_back({2'd1, tlen(p)});
            exp_q.push_back({2'd1, tlen(p)});
            conv_enable = 1'b1;
            wait_done(2);
            conv_enable = 1'b0;
            tick(2);
            cmp({31'h0, integrating}, 32'h0);
            cmp({31'h0, conv_done}, 32'h1);
        end
        $display("test free running done");
        wr(5'h01, 8'h00);
        exp_q.push_back({2'd1, 32'h0000_0014});
        exp_q.push_back({2'd1, 32'h0000_0050});
        conv_enable = 1'b1;
        tick(2);
        cmp({31'h0, conv_done}, 32'h0);
        wr(5'h01, 8'h02);
        wait_done(2);
        conv_enable = 1'b0;
        tick(2);
        k = 5 + int'($urandom % 30);
        wr(5'h01, 8'h10);
        exp_q.push_back({2'd1, 32'(k)});
        conv_enable = 1'b1;
        tick(k);
        conv_enable = 1'b0;
        wait_done(1);
        $display("test manual done");
        wr(5'h01, 8'h20);
        exp_q.push_back({2'd1, 32'h0000_0014});
        conv_enable = 1'b1;
        pulses(9'h001);
        k = 0;
        t = 0;
        while (integrating !== 1'b1 && t < 3000) begin
            tick(1);
            t++;
            if (sync_pin === 1'b1) k++;
        end
        if (t >= 3000) begin
            n_errors++;
            print_verdict();
        end
        cmp({31'h0, k >= 48 && k <= 56}, 32'h1);
        wait_done(1);
        wait_idle();
        pulses(9'h001);
        k = 0;
        t = 0;
        while (busy === 1'b1 && t < 12000) begin
            tick(1);
            t++;
            if (integrating !== 1'b0) k++;
        end
        if (t >= 12000) begin
            n_errors++;
            print_verdict();
        end
        cmp(32'(k), 32'h0);
        conv_enable = 1'b0;
        tick(2);
        $display("test one shot done");
        for (int p = 0; p < 4; p++) begin
            stop_rise = p[0];
            wr(5'h01, {1'b0, p[0], 2'b11, 4'(p)});
            exp_q.push_back({2'd2, 32'(1 << p)});
            conv_enable = 1'b1;
            tick(2);
            pulses(9'(1 << p));
            wait_done(1);
            conv_enable = 1'b0;
            wait_idle();
        end
        $display("test accumulate done");
        print_verdict();
    end
endmodule : tb_top
